// ---- hdl/tcm_cfg.svh ----
// Constants of the 16-bit timer with compare outputs: offsets, fields, codes.
// Assumes a plain register port with word addresses and 16-bit data.
// How it works
// - action bits steer state and pin source
// - reset clears every compare output state
// - nonzero action puts state on pin
// - state settable while pin driver off
// - action bits never touch capture
// - action zero leaves state unchanged
// - new action applies from next match
// - force strobe applies action at once
// - counting follows mode select only
// - non-PWM action sets, clears or toggles
// - mode 0 counts up, wraps freely
// - overflow flag set as counter wraps from max
// - overflow flag cleared when serviced
// - counter writable any time in normal
// - clear on match A or capture top
// - top match sets A or capture flag
// - top unbuffered, low top wraps first
// - toggle on match gives half-period wave
// - timer clock divided by 1..1024
// - overflow set passing max to zero
// - match sets compare flag on tick
// - force sets no flag, keeps counter
// - counter write blocks next tick's matches
// - flags clear on service or one written
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH

// ********************************************************************
// Register word addresses
// ********************************************************************
`define TCM_ADDR_W 3
`define TCM_REG_CTRL 3'h0
`define TCM_REG_COUNT 3'h1
`define TCM_REG_CMPA 3'h2
`define TCM_REG_CMPB 3'h3
`define TCM_REG_CAPT 3'h4
`define TCM_REG_FLAGS 3'h5
`define TCM_REG_PORT 3'h6
`define TCM_REG_STATUS 3'h7

// ********************************************************************
// Fields of the control word
// ********************************************************************
`define TCM_CTRL_MODE_LSB 0
`define TCM_CTRL_ACTA_LSB 4
`define TCM_CTRL_ACTB_LSB 6
`define TCM_CTRL_PSEL_LSB 8
`define TCM_CTRL_FORCEA_BIT 14
`define TCM_CTRL_FORCEB_BIT 15

// Flag bits
`define TCM_FLAG_OVF_BIT 0
`define TCM_FLAG_CMPA_BIT 1
`define TCM_FLAG_CMPB_BIT 2
`define TCM_FLAG_CAPT_BIT 3

// ********************************************************************
// Codes and values
// ********************************************************************
`define TCM_MODE_NORMAL 4'h0
`define TCM_MODE_CTC_CMPA 4'h4
`define TCM_MODE_CTC_CAPT 4'hC
`define TCM_MODE_RESERVED 4'hD
`define TCM_ACT_NONE 2'h0
`define TCM_ACT_TOGGLE 2'h1
`define TCM_ACT_CLEAR 2'h2
`define TCM_ACT_SET 2'h3
`define TCM_COUNT_MAX 16'hFFFF
`define TCM_COUNT_BOTTOM 16'h0000
`define TCM_RESET_WORD 16'h0000
`define TCM_DIV_1 11'h001
`define TCM_DIV_8 11'h008
`define TCM_DIV_64 11'h040
`define TCM_DIV_256 11'h100
`define TCM_DIV_1024 11'h400

`endif

// ---- hdl/tcm_chan.sv ----
// One compare output channel: the state flop and the pin override.
// Assumes match and force are one-cycle pulses on mclk.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_cfg.svh"

module tcm_chan (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire tcm_pkg::tcm_act_t act,
    input wire logic match,
    input wire logic force_cmp,
    // Ordinary port bit
    input wire logic port_data,
    input wire logic port_dir,
    // Outputs
    output logic state,
    output logic pin_out,
    output logic pin_oe
);
    import tcm_pkg::*;

    tcm_chan_s q;
    tcm_chan_s d;

    always_comb begin
        d = q;
        // Force acts exactly like a match on the state only
        if (match || force_cmp) begin
            case (act)
                `TCM_ACT_TOGGLE: d.state = ~q.state;
                `TCM_ACT_CLEAR: d.state = 1'b0;
                `TCM_ACT_SET: d.state = 1'b1;
                default: d.state = q.state;
            endcase
        end
        // Override the port value, never the direction
        d.pin_out = (act != `TCM_ACT_NONE) ? d.state : port_data;
        d.pin_oe = port_dir;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign state = q.state;
    assign pin_out = q.pin_out;
    assign pin_oe = q.pin_oe;

endmodule : tcm_chan

`default_nettype wire

// ---- hdl/tcm_pkg.sv ----
// Types and helpers shared by the timer core and its sub-blocks.
// Assumes tcm_cfg.svh is on the include path.
`include "tcm_cfg.svh"

package tcm_pkg;

    typedef logic [1:0] tcm_act_t;
    typedef logic [3:0] tcm_mode_t;

    // ****************************************************************
    // State records
    // ****************************************************************
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] cmpa;
        logic [15:0] cmpb;
        logic [15:0] capt;
        tcm_mode_t mode;
        tcm_act_t act_a;
        tcm_act_t act_b;
        logic [2:0] psel;
        logic tov;
        logic ocfa;
        logic ocfb;
        logic icf;
        logic block;
        logic force_a;
        logic force_b;
        logic [1:0] port_data;
        logic [1:0] port_dir;
        logic [2:0] cap_sync;
        logic [15:0] rdata;
    } tcm_core_s;

    typedef struct packed {
        logic state;
        logic pin_out;
        logic pin_oe;
    } tcm_chan_s;

    typedef struct packed {
        logic [10:0] cnt;
        logic tick;
    } tcm_pre_s;

    // Division factor of a prescaler code; zero means stopped
    function automatic logic [10:0] tcm_div(input logic [2:0] sel);
        case (sel)
            3'h1: tcm_div = `TCM_DIV_1;
            3'h2: tcm_div = `TCM_DIV_8;
            3'h3: tcm_div = `TCM_DIV_64;
            3'h4: tcm_div = `TCM_DIV_256;
            3'h5: tcm_div = `TCM_DIV_1024;
            default: tcm_div = 11'h000;
        endcase
    endfunction : tcm_div

    // Modes where the force strobe applies; set/clear/toggle actions apply in every mode
    function automatic logic tcm_non_pwm(input tcm_mode_t m);
        tcm_non_pwm = (m == `TCM_MODE_NORMAL) || (m == `TCM_MODE_CTC_CMPA) ||
            (m == `TCM_MODE_CTC_CAPT) || (m == `TCM_MODE_RESERVED);
    endfunction : tcm_non_pwm

endpackage : tcm_pkg

// ---- hdl/tcm_prescale.sv ----
// Timer clock generator: one-cycle tick every N system clocks.
// Assumes the select code comes from a register on the same clock.
`timescale 1ns/100ps
`default_nettype none

module tcm_prescale (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Divider select
    input wire logic [2:0] psel,
    // Timer tick
    output logic tick
);
    import tcm_pkg::*;

    tcm_pre_s q;
    tcm_pre_s d;
    logic [10:0] div;

    always_comb begin
        d = q;
        div = tcm_div(psel);
        d.tick = 1'b0;
        if (div == 11'h000) begin
            // Stopped: restart cleanly when a divider is chosen again
            d.cnt = 11'h000;
        end else if (q.cnt + 11'h001 >= div) begin
            d.cnt = 11'h000;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 11'h001;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule : tcm_prescale

`default_nettype wire

// ---- hdl/tcm_timer.sv ----
// Top of the 16-bit timer: counter, compare, capture, flags, registers.
// Assumes a plain register port on mclk and an asynchronous capture pin.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_cfg.svh"

module tcm_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [`TCM_ADDR_W-1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Service acknowledges from the vector logic
    input wire logic ovf_ack,
    input wire logic cmpa_ack,
    input wire logic cmpb_ack,
    input wire logic capt_ack,
    // Flag levels
    output logic overflow_flag,
    output logic compare_flag_a,
    output logic compare_flag_b,
    output logic capture_event_flag,
    // Capture pin
    input wire logic capture_pin,
    // Compare pins
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe
);
    import tcm_pkg::*;

    tcm_core_s q;
    tcm_core_s d;
    logic tick;
    logic state_a;
    logic state_b;
    logic hit_a;
    logic hit_b;
    logic hit_c;
    logic ctc_a;
    logic ctc_c;
    logic top_hit;
    logic cap_edge;
    logic wr_ctrl;
    logic wr_flags;

    // ****************************************************************
    // Timer clock
    // ****************************************************************
    tcm_prescale u_pre (
        .mclk(mclk),
        .rst(rst),
        .psel(q.psel),
        .tick(tick)
    );

    // ****************************************************************
    // Match detection
    // ****************************************************************
    always_comb begin
        ctc_a = (q.mode == `TCM_MODE_CTC_CMPA);
        ctc_c = (q.mode == `TCM_MODE_CTC_CAPT);
        // Matches only on a tick that no counter write has blocked
        hit_a = tick && !q.block && (q.count == q.cmpa);
        hit_b = tick && !q.block && (q.count == q.cmpb);
        hit_c = tick && !q.block && (q.count == q.capt);
        // Top is compared live, so a top below the count is passed by
        top_hit = (ctc_a && hit_a) || (ctc_c && hit_c);
        // Second and third sync stages agree on a rising change
        cap_edge = q.cap_sync[1] && !q.cap_sync[2];
        wr_ctrl = wr && (addr == `TCM_REG_CTRL);
        wr_flags = wr && (addr == `TCM_REG_FLAGS);
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;
        d.cap_sync = {q.cap_sync[1:0], capture_pin};
        d.force_a = 1'b0;
        d.force_b = 1'b0;

        // Counter; the sequence looks at the mode only
        if (wr && (addr == `TCM_REG_COUNT)) begin
            d.count = wdata;
            d.block = 1'b1;
        end else if (tick) begin
            d.block = 1'b0;
            if (top_hit) begin
                d.count = `TCM_COUNT_BOTTOM;
            end else begin
                d.count = q.count + 16'h0001;
            end
        end

        // Writable registers
        if (wr_ctrl) begin
            d.mode = wdata[`TCM_CTRL_MODE_LSB +: 4];
            d.act_a = wdata[`TCM_CTRL_ACTA_LSB +: 2];
            d.act_b = wdata[`TCM_CTRL_ACTB_LSB +: 2];
            d.psel = wdata[`TCM_CTRL_PSEL_LSB +: 3];
            // Strobe judged against the mode being written
            d.force_a = wdata[`TCM_CTRL_FORCEA_BIT] &&
                tcm_non_pwm(wdata[`TCM_CTRL_MODE_LSB +: 4]);
            d.force_b = wdata[`TCM_CTRL_FORCEB_BIT] &&
                tcm_non_pwm(wdata[`TCM_CTRL_MODE_LSB +: 4]);
        end
        if (wr && (addr == `TCM_REG_CMPA)) begin
            d.cmpa = wdata;
        end
        if (wr && (addr == `TCM_REG_CMPB)) begin
            d.cmpb = wdata;
        end
        if (wr && (addr == `TCM_REG_CAPT)) begin
            d.capt = wdata;
        end
        if (wr && (addr == `TCM_REG_PORT)) begin
            d.port_data = wdata[1:0];
            d.port_dir = wdata[9:8];
        end

        // Capture unit: ignores action bits, idle while it holds top
        if (cap_edge && !ctc_c) begin
            d.capt = q.count;
        end

        // Flags: clears first, sets last so a set wins
        if (wr_flags && wdata[`TCM_FLAG_OVF_BIT]) begin
            d.tov = 1'b0;
        end
        if (ovf_ack) begin
            d.tov = 1'b0;
        end
        if ((wr_flags && wdata[`TCM_FLAG_CMPA_BIT]) || cmpa_ack) begin
            d.ocfa = 1'b0;
        end
        if ((wr_flags && wdata[`TCM_FLAG_CMPB_BIT]) || cmpb_ack) begin
            d.ocfb = 1'b0;
        end
        if ((wr_flags && wdata[`TCM_FLAG_CAPT_BIT]) || capt_ack) begin
            d.icf = 1'b0;
        end
        // Counter write has priority, so no overflow on that cycle
        if (tick && !(wr && (addr == `TCM_REG_COUNT)) && (q.count == `TCM_COUNT_MAX)) begin
            d.tov = 1'b1;
        end
        if (hit_a) begin
            d.ocfa = 1'b1;
        end
        if (hit_b) begin
            d.ocfb = 1'b1;
        end
        if ((ctc_c && hit_c) || (cap_edge && !ctc_c)) begin
            d.icf = 1'b1;
        end

        // Read data, valid only in the cycle after the strobe
        d.rdata = `TCM_RESET_WORD;
        if (rd) begin
            case (addr)
                `TCM_REG_CTRL: d.rdata = {5'h00, q.psel, q.act_b, q.act_a, q.mode};
                `TCM_REG_COUNT: d.rdata = q.count;
                `TCM_REG_CMPA: d.rdata = q.cmpa;
                `TCM_REG_CMPB: d.rdata = q.cmpb;
                `TCM_REG_CAPT: d.rdata = q.capt;
                `TCM_REG_FLAGS: d.rdata = {12'h000, q.icf, q.ocfb, q.ocfa, q.tov};
                `TCM_REG_PORT: d.rdata = {6'h00, q.port_dir, 6'h00, q.port_data};
                `TCM_REG_STATUS: d.rdata = {13'h0000, q.block, state_b, state_a};
                default: d.rdata = `TCM_RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Compare output channels
    // ****************************************************************
    tcm_chan u_chan_a (
        .mclk(mclk),
        .rst(rst),
        .act(q.act_a),
        .match(hit_a),
        .force_cmp(q.force_a),
        .port_data(q.port_data[0]),
        .port_dir(q.port_dir[0]),
        .state(state_a),
        .pin_out(pin_a_out),
        .pin_oe(pin_a_oe)
    );

    tcm_chan u_chan_b (
        .mclk(mclk),
        .rst(rst),
        .act(q.act_b),
        .match(hit_b),
        .force_cmp(q.force_b),
        .port_data(q.port_data[1]),
        .port_dir(q.port_dir[1]),
        .state(state_b),
        .pin_out(pin_b_out),
        .pin_oe(pin_b_oe)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata = q.rdata;
    assign overflow_flag = q.tov;
    assign compare_flag_a = q.ocfa;
    assign compare_flag_b = q.ocfb;
    assign capture_event_flag = q.icf;

endmodule : tcm_timer

`default_nettype wire

// ---- tb/tcm_load.sv ----
// External load on compare pin A: pad level and spacing of its edges.
// Assumes pin value and enable come registered on the same clock.
`timescale 1ns/100ps
`default_nettype none

module tcm_load (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Pin drive
    input wire logic pin_out,
    input wire logic pin_oe,
    // Pad view
    output logic level,
    output logic [15:0] gap
);
    logic [15:0] since_q;

    // Undriven pad wanders, so a stale value never passes for a drive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level <= 1'b0;
            since_q <= 16'h0001;
            gap <= 16'h0000;
        end else begin
            level <= pin_oe ? pin_out : ~level;
            if (pin_oe && (pin_out != level)) begin
                gap <= since_q;
                since_q <= 16'h0001;
            end else begin
                since_q <= since_q + 16'h0001;
            end
        end
    end
endmodule : tcm_load

`default_nettype wire

// ---- tb/tcm_timer_assertions.sv ----
// Checker for the timer top: flag holding, pin source and forced compares.
// Assumes it is bound into tcm_timer and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_cfg.svh"

module tcm_timer_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [`TCM_ADDR_W-1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    // Acknowledges
    input wire logic ovf_ack,
    input wire logic cmpa_ack,
    input wire logic cmpb_ack,
    input wire logic capt_ack,
    // Flags
    input wire logic overflow_flag,
    input wire logic compare_flag_a,
    input wire logic compare_flag_b,
    input wire logic capture_event_flag,
    // Pins
    input wire logic capture_pin,
    input wire logic pin_a_out,
    input wire logic pin_a_oe,
    input wire logic pin_b_out,
    input wire logic pin_b_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic [1:0] act_a_q;
    logic run_q;
    logic ctrl_wr;
    logic port_wr;
    logic flag_wr;

    assign ctrl_wr = wr && (addr == `TCM_REG_CTRL);
    assign port_wr = wr && (addr == `TCM_REG_PORT);
    assign flag_wr = wr && (addr == `TCM_REG_FLAGS);

    // Last action A and whether the prescaler was left running
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            act_a_q <= 2'h0;
            run_q <= 1'b0;
        end else if (ctrl_wr) begin
            act_a_q <= wdata[5:4];
            run_q <= wdata[10:8] != 3'h0;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    reset_outputs_a: assert property ($fell(rst) |-> !pin_a_out && !pin_b_out && !pin_a_oe && !compare_flag_a)
        else $error("outputs not clear after reset");
    ovf_hold_a: assert property (overflow_flag && !ovf_ack && !(flag_wr && wdata[0]) |=> overflow_flag)
        else $error("overflow flag dropped on its own");
    cmpa_hold_a: assert property (compare_flag_a && !cmpa_ack && !(flag_wr && wdata[1]) |=> compare_flag_a)
        else $error("compare flag A dropped on its own");
    ovf_ack_clear_a: assert property (overflow_flag && ovf_ack && !run_q |=> !overflow_flag)
        else $error("overflow flag kept after service");
    cmpa_w1c_a: assert property (compare_flag_a && flag_wr && wdata[1] && !run_q |=> !compare_flag_a)
        else $error("compare flag A kept after write of one");
    force_level_a: assert property (ctrl_wr && wdata[14] && wdata[5] && wdata[3:0] == `TCM_MODE_NORMAL
        |-> ##[1:4] pin_a_out == act_a_q[0])
        else $error("forced action A not on pin");
    force_noflag_a: assert property (ctrl_wr && wdata[14] && !run_q && wdata[10:8] == 3'h0 && !compare_flag_a
        |=> !compare_flag_a [*4])
        else $error("force raised compare flag A");
    pin_dir_a: assert property (port_wr |-> ##2 pin_a_oe == $past(wdata[8], 2))
        else $error("pin A enable not from direction bit");
    pin_port_a: assert property (port_wr && act_a_q == `TCM_ACT_NONE |-> ##2 pin_a_out == $past(wdata[0], 2))
        else $error("pin A not from port data with no action");

    cover property (ctrl_wr && wdata[14]);
    cover property ($rose(overflow_flag));
    cover property ($rose(capture_event_flag));
endmodule : tcm_timer_chk

bind tcm_timer tcm_timer_chk u_chk (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ovf_ack(ovf_ack), .cmpa_ack(cmpa_ack), .cmpb_ack(cmpb_ack), .capt_ack(capt_ack),
    .overflow_flag(overflow_flag), .compare_flag_a(compare_flag_a), .compare_flag_b(compare_flag_b),
    .capture_event_flag(capture_event_flag), .capture_pin(capture_pin), .pin_a_out(pin_a_out),
    .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));

`default_nettype wire

// ---- tb/tcm_timer_bench.sv ----
// Bench for the timer: register tasks, compare output and counting checks.
// Assumes the checker is bound to the timer and the load model sits on pin A.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_cfg.svh"

module tcm_timer_bench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [`TCM_ADDR_W-1:0] addr = '0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, ovf_ack = 1'b0, cmpa_ack = 1'b0;
    logic cmpb_ack = 1'b0, capt_ack = 1'b0, capture_pin = 1'b0;
    logic [15:0] rdata, v, gap;
    logic ovf, cfa, cfb, icf, pa, pa_oe, pb, pb_oe, level;
    logic [1:0] acts [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic exps [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    int n_fail = 0;
    int compares = 0;

    always #10 mclk = ~mclk;

    tcm_timer dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ovf_ack(ovf_ack), .cmpa_ack(cmpa_ack), .cmpb_ack(cmpb_ack), .capt_ack(capt_ack),
        .overflow_flag(ovf), .compare_flag_a(cfa), .compare_flag_b(cfb), .capture_event_flag(icf),
        .capture_pin(capture_pin), .pin_a_out(pa), .pin_a_oe(pa_oe), .pin_b_out(pb), .pin_b_oe(pb_oe));

    tcm_load load_a (.mclk(mclk), .rst(rst), .pin_out(pa), .pin_oe(pa_oe), .level(level), .gap(gap));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [2:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        v = rdata;
    endtask : rreg

    // Ends off the edge so outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rreg(`TCM_REG_STATUS);
        check(v, 16'h0000);
        // Forced actions with the driver still off
        for (int i = 0; i < 4; i++) begin
            wreg(`TCM_REG_CTRL, {8'h40, 2'h0, acts[i], 4'h0});
            tick(4);
            rreg(`TCM_REG_STATUS);
            check({15'h0, v[0]}, {15'h0, exps[i]});
            check({15'h0, pa_oe}, 16'h0000);
        end
        rreg(`TCM_REG_FLAGS);
        check(v, 16'h0000);
        wreg(`TCM_REG_PORT, 16'h0100);
        tick(3);
        check({14'h0, pa_oe, level}, 16'h0002);
        wreg(`TCM_REG_CTRL, 16'h0030);
        tick(3);
        check({15'h0, level}, 16'h0001);
        // Counter write hides the match of the following tick
        wreg(`TCM_REG_CMPA, 16'h0007);
        for (int k = 0; k < 2; k++) begin
            wreg(`TCM_REG_COUNT, 16'h0006 + 16'(k));
            wreg(`TCM_REG_FLAGS, 16'h000F);
            tick(1);
            check({15'h0, cfa}, 16'h0000);
            wreg(`TCM_REG_CTRL, 16'h0100);
            tick(20);
            wreg(`TCM_REG_CTRL, 16'h0000);
            check({15'h0, cfa}, {15'h0, k == 0});
        end
        // Normal mode wrap
        wreg(`TCM_REG_COUNT, 16'hFFFD);
        wreg(`TCM_REG_CTRL, 16'h0100);
        tick(1);
        check({15'h0, ovf}, 16'h0000);
        tick(10);
        wreg(`TCM_REG_CTRL, 16'h0000);
        check({15'h0, ovf}, 16'h0001);
        rreg(`TCM_REG_COUNT);
        check({15'h0, v < 16'h0020}, 16'h0001);
        @(posedge mclk);
        ovf_ack <= 1'b1;
        @(posedge mclk);
        ovf_ack <= 1'b0;
        tick(2);
        check({15'h0, ovf}, 16'h0000);
        // Clear on match A with toggling pin
        wreg(`TCM_REG_CMPA, 16'h0003);
        wreg(`TCM_REG_COUNT, 16'h0000);
        wreg(`TCM_REG_FLAGS, 16'h000F);
        wreg(`TCM_REG_CTRL, 16'h0114);
        tick(40);
        check(gap, 16'h0004);
        check({15'h0, cfa}, 16'h0001);
        rreg(`TCM_REG_COUNT);
        check({15'h0, v <= 16'h0003}, 16'h0001);
        // Count above top runs through the wrap first
        wreg(`TCM_REG_COUNT, 16'hFFF0);
        wreg(`TCM_REG_FLAGS, 16'h000F);
        tick(4);
        check({14'h0, ovf, cfa}, 16'h0000);
        tick(20);
        check({14'h0, ovf, cfa}, 16'h0003);
        wreg(`TCM_REG_CTRL, 16'h0014);
        tick(3);
        @(posedge mclk);
        cmpa_ack <= 1'b1;
        @(posedge mclk);
        cmpa_ack <= 1'b0;
        tick(2);
        check({15'h0, cfa}, 16'h0000);
        // Clear on match with the capture register as top
        wreg(`TCM_REG_CAPT, 16'h0002);
        wreg(`TCM_REG_COUNT, 16'h0000);
        wreg(`TCM_REG_FLAGS, 16'h000F);
        wreg(`TCM_REG_CTRL, 16'h010C);
        tick(20);
        check({15'h0, icf}, 16'h0001);
        check({15'h0, cfb}, 16'h0001);
        rreg(`TCM_REG_COUNT);
        check({15'h0, v <= 16'h0002}, 16'h0001);
        // Capture with the counter parked and an action selected
        wreg(`TCM_REG_CTRL, 16'h0030);
        wreg(`TCM_REG_COUNT, 16'h1234);
        wreg(`TCM_REG_FLAGS, 16'h000F);
        @(posedge mclk);
        capture_pin <= 1'b1;
        tick(6);
        check({15'h0, icf}, 16'h0001);
        rreg(`TCM_REG_CAPT);
        check(v, 16'h1234);
        // Channel B forced high and driven
        wreg(`TCM_REG_PORT, 16'h0200);
        wreg(`TCM_REG_CTRL, 16'h80C0);
        tick(3);
        check({14'h0, pb_oe, pb}, 16'h0003);
        print_verdict();
    end
endmodule : tcm_timer_bench

`default_nettype wire
